//--- verilog/flb_top.sv
`default_nettype none
// ***************************************************
// Transmit FIFO
// ***************************************************
module flb_fifo #(
    parameter int W = 10,
    parameter int D = 4
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic flush_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o,
    output logic [$clog2(D):0] count_o
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } flb_fst_t;
    flb_fst_t st, next_st;
    logic push, pop;
    assign in_ready_o = (st.cnt != (AW+1)'(D));
    assign out_valid_o = (st.cnt != '0);
    assign out_data_o = st.mem[st.rp];
    assign count_o = st.cnt;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    always_comb begin
        next_st = st;
        if (flush_i) begin
            next_st.wp = '0;
            next_st.rp = '0;
            next_st.cnt = '0;
        end else begin
            if (push) begin
                next_st.mem[st.wp] = in_data_i;
                next_st.wp = AW'(st.wp + 1'b1);
            end
            if (pop) begin
                next_st.rp = AW'(st.rp + 1'b1);
            end
            next_st.cnt = (AW+1)'(st.cnt + push - pop);
        end
    end
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ***************************************************
// Break and flow control
// ***************************************************
module flb_top
    import flb_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Terminal side
    input wire logic term_valid_i,
    input wire logic [7:0] term_data_i,
    output logic term_ready_o,
    input wire logic brk_i,
    input wire logic rts_i,
    output logic cts_o,
    output logic dte_valid_o,
    output logic [7:0] dte_data_o,
    input wire logic dte_ready_i,
    // Remote side
    output logic line_valid_o,
    output logic [7:0] line_data_o,
    output logic line_brk_o,
    output logic line_flush_o,
    input wire logic line_ready_i,
    input wire logic rem_valid_i,
    input wire logic [7:0] rem_data_i,
    output logic rem_ready_o,
    input wire logic ec_i
);
    localparam int CW = $clog2(DEPTH) + 1;
    typedef struct packed {
        flb_ap_t ap;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [1:0] brk_mode;
        logic [4:0] flow;
        logic rts_s1;
        logic rts_s2;
        logic pend_brk;
        logic pend_xbrk;
        logic pend_fl;
        logic term_rdy;
        logic cts;
        logic dte_paused;
        logic rem_paused;
        logic term_xoff;
        logic rem_xoff;
        logic dte_valid;
        logic [7:0] dte_data;
        logic rem_rdy;
        logic line_valid;
        flb_item_t line;
    } flb_st_t;
    flb_st_t st, next_st;
    logic f_push, f_pop, f_flush, f_in_rdy, f_out_vld;
    flb_item_t f_in, f_out;
    logic [CW-1:0] f_cnt;
    logic loc_rx, loc_tx, pass, intl, hw, paused;
    logic t_acc, t_fc, r_acc, r_fc, dte_free, dte_load;
    logic wr, brk_ok, flow_ok, line_free, need_rx, need_rxon;
    logic need_tx, need_txon;
    logic [7:0] wv;

    flb_fifo #(.W($bits(flb_item_t)), .D(DEPTH)) u_fifo (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .flush_i(f_flush),
        .in_valid_i(f_push),
        .in_ready_o(f_in_rdy),
        .in_data_i(f_in),
        .out_valid_o(f_out_vld),
        .out_ready_i(f_pop),
        .out_data_o(f_out),
        .count_o(f_cnt)
    );

    always_comb begin
        // Mode decode
        hw = (st.flow == FC_HW);
        loc_rx = st.flow inside {FC_LOC, FC_PASS, FC_BOTH, FC_INTB};
        loc_tx = st.flow inside {FC_LOC, FC_BOTH, FC_INTB};
        pass = st.flow inside {FC_PASS, FC_BOTH, FC_INTB};
        // Internal only on links without error control
        intl = (st.flow inside {FC_INT, FC_INTB}) && !ec_i;
        paused = (loc_rx && st.dte_paused) || (hw && !st.rts_s2);
        wv = pwdata_i[7:0];
        wr = psel_i && penable_i && st.pready && pwrite_i;
        brk_ok = (pwdata_i[31:2] == '0) && (pwdata_i[1:0] != 2'h3);
        flow_ok = (pwdata_i[31:5] == '0) && (pwdata_i[4:0] inside
            {FC_OFF, FC_HW, FC_LOC, FC_PASS, FC_BOTH, FC_INT, FC_INTB});
        next_st = st;
        // ***************************************************
        // APB slave, one wait state
        // ***************************************************
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        case (st.ap)
            AP_IDLE: begin
                if (psel_i && penable_i) begin
                    next_st.ap = AP_RESP;
                    next_st.pready = 1'b1;
                    next_st.prdata = '0;
                    case (paddr_i)
                        ADDR_BRK: next_st.prdata[1:0] = st.brk_mode;
                        ADDR_FLOW: next_st.prdata[4:0] = st.flow;
                        ADDR_ALT: next_st.prdata = '0;
                        ADDR_STAT: next_st.prdata[11:0] = {st.rts_s2,
                            st.cts, f_cnt[2:0], st.rem_xoff, st.term_xoff,
                            st.rem_paused, st.dte_paused, st.pend_brk,
                            st.pend_xbrk, st.dte_valid};
                        default: next_st.pslverr = 1'b1;
                    endcase
                end
            end
            AP_RESP: next_st.ap = AP_IDLE;
            default: next_st.ap = AP_IDLE;
        endcase
        if (wr && paddr_i == ADDR_BRK && brk_ok) begin
            next_st.brk_mode = pwdata_i[1:0];
        end
        if (wr && paddr_i == ADDR_FLOW && flow_ok) begin
            next_st.flow = pwdata_i[4:0];
        end
        if (wr && paddr_i == ADDR_ALT && pwdata_i[31:8] == '0) begin
            case (wv)
                ALT_DST: next_st.brk_mode = BRK_DST;
                ALT_EXP: next_st.brk_mode = BRK_EXP;
                ALT_SEQ: next_st.brk_mode = BRK_SEQ;
                default: next_st.brk_mode = st.brk_mode;
            endcase
        end
        // ***************************************************
        // Terminal to remote path
        // ***************************************************
        next_st.rts_s1 = rts_i;
        next_st.rts_s2 = st.rts_s1;
        t_acc = term_valid_i && st.term_rdy;
        t_fc = term_data_i inside {CH_XON, CH_XOFF};
        f_flush = brk_i && (st.brk_mode == BRK_DST);
        f_push = 1'b0;
        f_in = '0;
        if (t_acc && t_fc && loc_rx) begin
            next_st.dte_paused = (term_data_i == CH_XOFF);
        end
        if (t_acc && !(t_fc && loc_rx && !pass)) begin
            f_push = 1'b1;
            f_in.data = term_data_i;
        end else if (st.pend_brk && f_in_rdy) begin
            f_push = 1'b1;
            f_in.brk = 1'b1;
            next_st.pend_brk = 1'b0;
        end
        if (f_flush) begin
            f_push = 1'b0;
        end
        if (brk_i) begin
            case (st.brk_mode)
                BRK_SEQ: next_st.pend_brk = 1'b1;
                BRK_EXP: next_st.pend_xbrk = 1'b1;
                BRK_DST: begin
                    next_st.pend_xbrk = 1'b1;
                    next_st.pend_fl = 1'b1;
                    next_st.pend_brk = 1'b0;
                end
                default: next_st.pend_xbrk = 1'b1;
            endcase
        end
        // Room for one more is kept so a late ready never loses a word
        next_st.term_rdy = (f_cnt <= CW'(DEPTH - 2)) && !f_flush;
        next_st.cts = hw ? (f_cnt <= CW'(DEPTH - 2)) : 1'b1;
        need_tx = loc_tx && !st.term_xoff && (f_cnt >= CW'(DEPTH - 1));
        need_txon = loc_tx && st.term_xoff && (f_cnt == '0);
        if (!loc_tx) begin
            next_st.term_xoff = 1'b0;
        end
        // ***************************************************
        // Line output, expedited break first
        // ***************************************************
        line_free = !st.line_valid || line_ready_i;
        need_rx = intl && !st.rem_xoff && st.dte_valid && !dte_ready_i;
        need_rxon = st.rem_xoff && !st.dte_valid;
        f_pop = 1'b0;
        if (line_ready_i) begin
            next_st.line_valid = 1'b0;
        end
        if (line_free) begin
            if (st.pend_xbrk) begin
                next_st.line_valid = 1'b1;
                next_st.line = '{flush: st.pend_fl, brk: 1'b1,
                    data: 8'h00};
                next_st.pend_xbrk = brk_i && st.brk_mode != BRK_SEQ;
                next_st.pend_fl = brk_i && st.brk_mode == BRK_DST;
            end else if (need_rx || need_rxon) begin
                next_st.line_valid = 1'b1;
                next_st.line = '{flush: 1'b0, brk: 1'b0,
                    data: need_rx ? CH_XOFF : CH_XON};
                next_st.rem_xoff = need_rx;
            end else if (f_out_vld && !st.rem_paused && !f_flush) begin
                f_pop = 1'b1;
                next_st.line_valid = 1'b1;
                next_st.line = f_out;
            end
        end
        if (!intl) begin
            next_st.rem_paused = 1'b0;
        end
        // ***************************************************
        // Remote to terminal path
        // ***************************************************
        r_acc = rem_valid_i && st.rem_rdy;
        r_fc = rem_data_i inside {CH_XON, CH_XOFF};
        dte_free = !st.dte_valid || dte_ready_i;
        dte_load = 1'b0;
        if (dte_ready_i) begin
            next_st.dte_valid = 1'b0;
        end
        if (r_acc && r_fc && intl) begin
            next_st.rem_paused = (rem_data_i == CH_XOFF);
        end else if (r_acc) begin
            dte_load = 1'b1;
            next_st.dte_valid = 1'b1;
            next_st.dte_data = rem_data_i;
        end else if (dte_free && (need_tx || need_txon)) begin
            next_st.dte_valid = 1'b1;
            next_st.dte_data = need_tx ? CH_XOFF : CH_XON;
            next_st.term_xoff = need_tx;
        end
        if (f_flush) begin
            next_st.dte_valid = 1'b0;
        end
        next_st.rem_rdy = !next_st.dte_valid && !paused && !f_flush;
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '0;
            st.ap <= AP_IDLE;
            st.brk_mode <= BRK_RST;
            st.flow <= FC_RST;
        end else begin
            st <= next_st;
        end
    end

    assign prdata_o = st.prdata;
    assign pready_o = st.pready;
    assign pslverr_o = st.pslverr;
    assign term_ready_o = st.term_rdy;
    assign cts_o = st.cts;
    assign dte_valid_o = st.dte_valid;
    assign dte_data_o = st.dte_data;
    assign rem_ready_o = st.rem_rdy;
    assign line_valid_o = st.line_valid;
    assign line_data_o = st.line.data;
    assign line_brk_o = st.line.brk;
    assign line_flush_o = st.line.flush;

    // ***************************************************
    // Checks
    // ***************************************************
    sequence s_xbrk_req;
        brk_i && st.brk_mode == BRK_EXP;
    endsequence
    sequence s_xbrk_out;
        line_valid_o && line_brk_o && !line_flush_o;
    endsequence
    property p_seq_keep;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        st.brk_mode == BRK_SEQ && brk_i |=> !line_flush_o && st.pend_brk
            && f_cnt + 1 >= $past(f_cnt);
    endproperty
    a_seq_keep: assert property (p_seq_keep)
        else $error("in-order break lost data or flushed");
    property p_exp_now;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        s_xbrk_req ##0 (!line_valid_o || line_ready_i) |=>
            (!line_valid_o || line_ready_i) [*1] ##0 1'b1 |=> s_xbrk_out;
    endproperty
    a_exp_now: assert property (p_exp_now)
        else $error("expedited break not sent ahead of data");
    property p_dst_flush;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        brk_i && st.brk_mode == BRK_DST |=> f_cnt == '0 && !dte_valid_o
            ##[0:40] (line_valid_o && line_brk_o && line_flush_o);
    endproperty
    a_dst_flush: assert property (p_dst_flush)
        else $error("destructive break did not flush");
    property p_alt_map;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        wr && paddr_i == ADDR_ALT && pwdata_i == 32'h00000003 |=>
            st.brk_mode == BRK_EXP;
    endproperty
    a_alt_map: assert property (p_alt_map)
        else $error("alternative break value 3 not mapped");
    property p_loc_drop;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        t_acc && t_fc && loc_rx && !pass |-> f_in.brk || !f_push;
    endproperty
    a_loc_drop: assert property (p_loc_drop)
        else $error("local flow character forwarded");
    property p_pass_fwd;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        t_acc && t_fc && pass && !f_flush |-> f_push ##1
            st.dte_paused == $past(term_data_i == CH_XOFF);
    endproperty
    a_pass_fwd: assert property (p_pass_fwd)
        else $error("pass-through character not acted on or forwarded");
    property p_rem_xoff;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        r_acc && intl && rem_data_i == CH_XOFF |=> !f_pop [*2];
    endproperty
    a_rem_xoff: assert property (p_rem_xoff)
        else $error("data sent after remote pause");
    property p_rem_hide;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        r_acc && r_fc && intl |-> !dte_load;
    endproperty
    a_rem_hide: assert property (p_rem_hide)
        else $error("remote flow character passed to terminal");
    property p_off_cts;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        st.flow == FC_OFF [*2] |-> cts_o && !st.term_xoff;
    endproperty
    a_off_cts: assert property (p_off_cts)
        else $error("flow control active with setting off");
    property p_bad_flow;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        wr && paddr_i == ADDR_FLOW && !flow_ok |=> $stable(st.flow);
    endproperty
    a_bad_flow: assert property (p_bad_flow)
        else $error("invalid flow setting accepted");
endmodule
`default_nettype wire

//--- inc/flb_pkg.sv
`default_nettype none
package flb_pkg;
    // ***************************************************
    // Register map
    // ***************************************************
    localparam logic [7:0] ADDR_BRK = 8'h00;
    localparam logic [7:0] ADDR_FLOW = 8'h04;
    localparam logic [7:0] ADDR_ALT = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    // ***************************************************
    // Break handling codes
    // ***************************************************
    localparam logic [1:0] BRK_SEQ = 2'h0;
    localparam logic [1:0] BRK_EXP = 2'h1;
    localparam logic [1:0] BRK_DST = 2'h2;
    localparam logic [1:0] BRK_RST = BRK_SEQ;
    localparam logic [7:0] ALT_DST = 8'h01;
    localparam logic [7:0] ALT_EXP = 8'h03;
    localparam logic [7:0] ALT_SEQ = 8'h05;
    // ***************************************************
    // Flow control codes
    // ***************************************************
    localparam logic [4:0] FC_OFF = 5'h00;
    localparam logic [4:0] FC_HW = 5'h03;
    localparam logic [4:0] FC_LOC = 5'h04;
    localparam logic [4:0] FC_PASS = 5'h08;
    localparam logic [4:0] FC_BOTH = 5'h0C;
    localparam logic [4:0] FC_INT = 5'h10;
    localparam logic [4:0] FC_INTB = 5'h14;
    localparam logic [4:0] FC_RST = FC_HW;
    // ***************************************************
    // In-band characters and sizes
    // ***************************************************
    localparam logic [7:0] CH_XON = 8'h11;
    localparam logic [7:0] CH_XOFF = 8'h13;
    localparam int FIFO_DEPTH = 4;
    // ***************************************************
    // Types
    // ***************************************************
    typedef struct packed {
        logic flush;
        logic brk;
        logic [7:0] data;
    } flb_item_t;
    typedef enum logic [1:0] {
        AP_IDLE = 2'b00,
        AP_RESP = 2'b01
    } flb_ap_t;
endpackage
`default_nettype wire

//--- sim/flb_term_model.sv
`default_nettype none
// ***************************************************
// Terminal equipment model
// ***************************************************
module flb_term_model
    import flb_pkg::*;
(
    // Clock, reset and bench control
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic use_cts_i,
    input wire logic stall_i,
    // Serial port
    output logic term_valid_o,
    output logic [7:0] term_data_o,
    input wire logic term_ready_i,
    input wire logic cts_i,
    output logic rts_o,
    input wire logic dte_valid_i,
    input wire logic [7:0] dte_data_i,
    output logic dte_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];
    assign dte_ready_o = !stall_i;
    assign rts_o = !stall_i;
    task automatic send(input logic [7:0] c);
        tx_q.push_back(c);
    endtask
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            term_valid_o <= 1'b0;
            term_data_o <= 8'hA5;
        end else begin
            if (dte_valid_i && dte_ready_o) begin
                rx_q.push_back(dte_data_i);
            end
            if (term_valid_o && term_ready_i) begin
                void'(tx_q.pop_front());
            end
            // Held request never withdrawn, idle data keeps moving
            if (!term_valid_o || term_ready_i) begin
                if (tx_q.size() > 0 && (!use_cts_i || cts_i)) begin
                    term_valid_o <= 1'b1;
                    term_data_o <= tx_q[0];
                end else begin
                    term_valid_o <= 1'b0;
                    term_data_o <= ~term_data_o;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/tb.sv
`default_nettype none
// ***************************************************
// Testbench
// ***************************************************
module tb
    import flb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] wa;
        logic [31:0] wd;
        logic [7:0] ra;
        logic [31:0] rv;
        logic err;
    } flb_row_t;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic brk = 1'b0;
    logic line_rdy = 1'b0;
    logic rem_valid = 1'b0;
    logic [7:0] rem_data = 8'h00;
    logic ec = 1'b1;
    logic use_cts = 1'b1;
    logic stall = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, term_valid, term_ready, rts, cts;
    logic dte_valid, dte_ready, line_valid, line_brk, line_flush, rem_ready;
    logic [7:0] term_data, dte_data, line_data;
    logic [9:0] lq[$];
    int failures = 0;
    int total_checks = 0;
    flb_row_t rows[16] = '{
        '{ADDR_BRK, 32'h1, ADDR_BRK, 32'h1, 1'b0},
        '{ADDR_BRK, 32'h2, ADDR_BRK, 32'h2, 1'b0},
        '{ADDR_BRK, 32'h3, ADDR_BRK, 32'h2, 1'b0},
        '{ADDR_ALT, 32'h5, ADDR_BRK, 32'h0, 1'b0},
        '{ADDR_ALT, 32'h3, ADDR_BRK, 32'h1, 1'b0},
        '{ADDR_ALT, 32'h1, ADDR_BRK, 32'h2, 1'b0},
        '{ADDR_ALT, 32'h7, ADDR_BRK, 32'h2, 1'b0},
        '{ADDR_FLOW, 32'h0, ADDR_FLOW, 32'h0, 1'b0},
        '{ADDR_FLOW, 32'h4, ADDR_FLOW, 32'h4, 1'b0},
        '{ADDR_FLOW, 32'h8, ADDR_FLOW, 32'h8, 1'b0},
        '{ADDR_FLOW, 32'hC, ADDR_FLOW, 32'hC, 1'b0},
        '{ADDR_FLOW, 32'h10, ADDR_FLOW, 32'h10, 1'b0},
        '{ADDR_FLOW, 32'h14, ADDR_FLOW, 32'h14, 1'b0},
        '{ADDR_FLOW, 32'h5, ADDR_FLOW, 32'h14, 1'b0},
        '{ADDR_STAT, 32'h0, ADDR_STAT, 32'hC00, 1'b0},
        '{8'h10, 32'h1, ADDR_ALT, 32'h0, 1'b1}
    };
    // Terminal control character forwarded or swallowed per setting
    logic [4:0] fw_fc[7] = '{FC_OFF, FC_HW, FC_LOC, FC_PASS, FC_BOTH, FC_INT,
        FC_INTB};
    logic fw_exp[7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (line_valid === 1'b1 && line_rdy) begin
            lq.push_back({line_flush, line_brk, line_data});
        end
    end
    flb_top #(.DEPTH(FIFO_DEPTH)) dut (
        .sys_clk_i(sys_clk), .resetn_i(resetn), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .term_valid_i(term_valid),
        .term_data_i(term_data), .term_ready_o(term_ready), .brk_i(brk),
        .rts_i(rts), .cts_o(cts), .dte_valid_o(dte_valid),
        .dte_data_o(dte_data), .dte_ready_i(dte_ready),
        .line_valid_o(line_valid), .line_data_o(line_data),
        .line_brk_o(line_brk), .line_flush_o(line_flush),
        .line_ready_i(line_rdy), .rem_valid_i(rem_valid),
        .rem_data_i(rem_data), .rem_ready_o(rem_ready), .ec_i(ec)
    );
    flb_term_model term (
        .sys_clk_i(sys_clk), .resetn_i(resetn), .use_cts_i(use_cts),
        .stall_i(stall), .term_valid_o(term_valid), .term_data_o(term_data),
        .term_ready_i(term_ready), .cts_i(cts), .rts_o(rts),
        .dte_valid_i(dte_valid), .dte_data_i(dte_data),
        .dte_ready_o(dte_ready)
    );
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string m);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s %h not %h", $time, m, got, exp);
        end
    endtask
    task automatic give_up(input string m);
        failures++;
        $display("wrong value at %0t: %s never came", $time, m);
        print_verdict();
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        tick(1);
        penable <= 1'b1;
        n = 0;
        do begin
            tick(1);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        tick(1);
        if (n >= 50) give_up("bus answer");
    endtask
    task automatic rem_send(input logic [7:0] c);
        int n;
        rem_valid <= 1'b1;
        rem_data <= c;
        n = 0;
        do begin
            tick(1);
            n++;
        end while (rem_ready !== 1'b1 && n < 100);
        rem_valid <= 1'b0;
        rem_data <= ~c;
        tick(1);
        if (n >= 100) give_up("remote ready");
    endtask
    task automatic wait_line(input int n);
        int t;
        t = 0;
        while (lq.size() < n && t < 300) begin
            tick(1);
            t++;
        end
        if (lq.size() < n) give_up("line item");
    endtask
    task automatic brk_case(input logic [1:0] m);
        int bi;
        int nd;
        apb(1'b1, ADDR_BRK, {30'h0, m});
        line_rdy <= 1'b0;
        lq.delete();
        term.send(8'h41);
        term.send(8'h42);
        term.send(8'h43);
        tick(10);
        brk <= 1'b1;
        tick(1);
        brk <= 1'b0;
        line_rdy <= 1'b1;
        wait_line(m == BRK_DST ? 1 : 4);
        tick(20);
        bi = -1;
        nd = 0;
        foreach (lq[k]) begin
            if (lq[k][8]) bi = k;
            else nd++;
        end
        if (m == BRK_SEQ) chk(bi, 3, "break position");
        if (m == BRK_EXP) chk(bi <= 1, 1, "break expedited");
        if (m != BRK_DST) chk(nd, 3, "data kept");
        if (m == BRK_DST) chk({nd <= 1, lq[bi][9]}, 3, "flush");
    endtask
    initial begin
        tick(3);
        resetn <= 1'b1;
        tick(2);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].wa, rows[i].wd);
            chk({31'h0, err}, {31'h0, rows[i].err}, "response");
            apb(1'b0, rows[i].ra, 32'h0);
            chk(rd, rows[i].rv, "register");
        end
        line_rdy <= 1'b1;
        foreach (fw_fc[i]) begin
            apb(1'b1, ADDR_FLOW, {27'h0, fw_fc[i]});
            use_cts <= (fw_fc[i] == FC_HW);
            lq.delete();
            term.send(CH_XON);
            term.send(8'h61);
            wait_line(1 + int'(fw_exp[i]));
            tick(10);
            chk(lq.size(), 1 + int'(fw_exp[i]), "forwarded");
            chk(lq[lq.size() - 1], 10'h061, "data");
        end
        resetn <= 1'b0;
        tick(3);
        resetn <= 1'b1;
        use_cts <= 1'b1;
        tick(2);
        apb(1'b0, ADDR_BRK, 32'h0);
        chk(rd, 32'h0, "break default");
        apb(1'b0, ADDR_FLOW, 32'h0);
        chk(rd, 32'h3, "flow default");
        brk_case(BRK_SEQ);
        brk_case(BRK_EXP);
        brk_case(BRK_DST);
        apb(1'b1, ADDR_FLOW, {27'h0, FC_INT});
        ec <= 1'b0;
        use_cts <= 1'b0;
        lq.delete();
        rem_send(CH_XOFF);
        rem_send(8'h7A);
        term.send(8'h62);
        tick(20);
        chk(lq.size(), 0, "line paused");
        rem_send(CH_XON);
        wait_line(1);
        chk(lq[0], 10'h062, "line resumed");
        chk({term.rx_q.size(), term.rx_q[0]}, 32'h17A, "to terminal");
        stall <= 1'b1;
        lq.delete();
        rem_send(8'h79);
        wait_line(1);
        chk(lq[0], {2'h0, CH_XOFF}, "remote stopped");
        stall <= 1'b0;
        wait_line(2);
        chk(lq[1], {2'h0, CH_XON}, "remote resumed");
        ec <= 1'b1;
        apb(1'b1, ADDR_FLOW, {27'h0, FC_LOC});
        term.rx_q.delete();
        term.send(CH_XOFF);
        tick(10);
        rem_valid <= 1'b1;
        rem_data <= 8'h71;
        tick(20);
        chk(term.rx_q.size(), 0, "terminal output paused");
        chk(rem_ready, 0, "remote held off");
        term.send(CH_XON);
        rem_send(8'h71);
        for (int t = 0; t < 100 && term.rx_q.size() == 0; t++) tick(1);
        chk(term.rx_q[0], 8'h71, "terminal output resumed");
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, ADDR_FLOW, i == 0 ? 32'h0 : 32'h3);
            line_rdy <= 1'b0;
            lq.delete();
            for (int k = 0; k < 6; k++) term.send(8'h30 + 8'(k));
            tick(20);
            chk(term_ready, 0, "buffer full");
            chk(cts, i == 0, "clear to send");
            line_rdy <= 1'b1;
            wait_line(6);
            foreach (lq[k]) chk(lq[k], 10'h030 + 10'(k), "drain");
        end
        print_verdict();
    end
endmodule
`default_nettype wire
